// >>> logic/cbsu_pkg.sv
`default_nettype none
package cbsu_pkg;

	localparam int PC_W = 16;
	localparam int DISP_W = 7;
	localparam int SEL_W = 3;
	localparam int FLAGS_W = 8;

	// Status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;

	// Program counter steps
	localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
	localparam logic [PC_W-1:0] SKIP_ONE_STEP = 16'h0002;
	localparam logic [PC_W-1:0] SKIP_TWO_STEP = 16'h0003;

	// Extra cycles beyond the first
	localparam logic [1:0] EXTRA_NONE = 2'h0;
	localparam logic [1:0] EXTRA_ONE = 2'h1;
	localparam logic [1:0] EXTRA_TWO = 2'h2;

	typedef enum logic [4:0] {
		OP_BRANCH_ON_FLAG_BIT_SET = 5'h00,
		OP_BRANCH_ON_FLAG_BIT_CLEARED = 5'h01,
		OP_BRANCH_IF_EQUAL = 5'h02,
		OP_BRANCH_IF_NOT_EQUAL = 5'h03,
		OP_BRANCH_IF_CARRY_SET = 5'h04,
		OP_BRANCH_IF_CARRY_CLEARED = 5'h05,
		OP_BRANCH_IF_SAME_OR_HIGHER = 5'h06,
		OP_BRANCH_IF_NEGATIVE = 5'h07,
		OP_BRANCH_IF_POSITIVE = 5'h08,
		OP_BRANCH_IF_SIGNED_GE = 5'h09,
		OP_BRANCH_IF_SIGNED_LESS = 5'h0a,
		OP_BRANCH_IF_HALF_CARRY_SET = 5'h0b,
		OP_BRANCH_IF_HALF_CARRY_CLEAR = 5'h0c,
		OP_BRANCH_IF_TRANSFER_SET = 5'h0d,
		OP_BRANCH_IF_TRANSFER_CLEAR = 5'h0e,
		OP_SKIP_IF_IO_BIT_SET = 5'h0f
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_DISCARD = 2'b10
	} state_e;

	// Register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_LAST_TARGET = 8'h08;
	localparam logic [ADDR_W-1:0] REG_EVAL_COUNT = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_TAKEN_COUNT = 8'h10;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_TAKEN_BIT = 1;
	localparam int STAT_SKIP_BIT = 2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
`default_nettype wire

// >>> logic/cond_eval.sv
`timescale 1ns/10ps
`default_nettype none
module cond_eval
	import cbsu_pkg::*;
#(
	parameter int PCW = PC_W
)
(
	// Decoded instruction
	input  wire op_e              op_i,
	input  wire logic [SEL_W-1:0] flag_sel_i,
	input  wire logic [DISP_W-1:0] disp_i,
	input  wire logic [PCW-1:0]   pc_i,
	input  wire logic             next_two_words_i,
	// Operand sources
	input  wire logic [FLAGS_W-1:0] flags_i,
	input  wire logic             io_bit_i,
	// Outcome
	output logic                  taken_o,
	output logic                  skip_o,
	output logic [PCW-1:0]        target_o,
	output logic [1:0]            extra_o
);

	logic [PCW-1:0] disp_ext;

	assign disp_ext = {{(PCW-DISP_W){disp_i[DISP_W-1]}}, disp_i};

	// Flags are only read here; nothing in the unit writes them
	always_comb
	begin
		skip_o = 1'b0;
		case (op_i)
			OP_BRANCH_ON_FLAG_BIT_SET: taken_o = flags_i[flag_sel_i] == 1'b1;
			OP_BRANCH_ON_FLAG_BIT_CLEARED: taken_o = flags_i[flag_sel_i] == 1'b0;
			OP_BRANCH_IF_EQUAL: taken_o = flags_i[FLAG_Z] == 1'b1;
			OP_BRANCH_IF_NOT_EQUAL: taken_o = flags_i[FLAG_Z] == 1'b0;
			OP_BRANCH_IF_CARRY_SET: taken_o = flags_i[FLAG_C] == 1'b1;
			OP_BRANCH_IF_CARRY_CLEARED,
			OP_BRANCH_IF_SAME_OR_HIGHER: taken_o = flags_i[FLAG_C] == 1'b0;
			OP_BRANCH_IF_NEGATIVE: taken_o = flags_i[FLAG_N] == 1'b1;
			OP_BRANCH_IF_POSITIVE: taken_o = flags_i[FLAG_N] == 1'b0;
			OP_BRANCH_IF_SIGNED_GE: taken_o = (flags_i[FLAG_N] ^ flags_i[FLAG_V]) == 1'b0;
			OP_BRANCH_IF_SIGNED_LESS: taken_o = (flags_i[FLAG_N] ^ flags_i[FLAG_V]) == 1'b1;
			OP_BRANCH_IF_HALF_CARRY_SET: taken_o = flags_i[FLAG_H] == 1'b1;
			OP_BRANCH_IF_HALF_CARRY_CLEAR: taken_o = flags_i[FLAG_H] == 1'b0;
			OP_BRANCH_IF_TRANSFER_SET: taken_o = flags_i[FLAG_T] == 1'b1;
			OP_BRANCH_IF_TRANSFER_CLEAR: taken_o = flags_i[FLAG_T] == 1'b0;
			OP_SKIP_IF_IO_BIT_SET:
			begin
				taken_o = io_bit_i == 1'b1;
				skip_o = 1'b1;
			end
			default: taken_o = 1'b0;
		endcase
	end

	always_comb
	begin
		if (!taken_o)
		begin
			target_o = pc_i + PC_STEP[PCW-1:0];
			extra_o = EXTRA_NONE;
		end
		else if (skip_o)
		begin
			target_o = pc_i + (next_two_words_i ? SKIP_TWO_STEP[PCW-1:0] : SKIP_ONE_STEP[PCW-1:0]);
			extra_o = next_two_words_i ? EXTRA_TWO : EXTRA_ONE;
		end
		else
		begin
			target_o = pc_i + disp_ext + PC_STEP[PCW-1:0];
			extra_o = EXTRA_ONE;
		end
	end

endmodule
`default_nettype wire

// >>> logic/conditional_branch_skip_unit.sv
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_skip_unit
	import cbsu_pkg::*;
#(
	parameter int PCW = PC_W
)
(
	// Clock and reset
	input  wire logic                mclk_i,
	input  wire logic                rst_i,

	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire logic [2:0]          s_axi_awprot_i,
	input  wire logic                s_axi_awvalid_i,
	output logic                     s_axi_awready_o,
	// AXI4-Lite write data
	input  wire logic [31:0]         s_axi_wdata_i,
	input  wire logic [3:0]          s_axi_wstrb_i,
	input  wire logic                s_axi_wvalid_i,
	output logic                     s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]               s_axi_bresp_o,
	output logic                     s_axi_bvalid_o,
	input  wire logic                s_axi_bready_i,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
	input  wire logic [2:0]          s_axi_arprot_i,
	input  wire logic                s_axi_arvalid_i,
	output logic                     s_axi_arready_o,
	// AXI4-Lite read data
	output logic [31:0]              s_axi_rdata_o,
	output logic [1:0]               s_axi_rresp_o,
	output logic                     s_axi_rvalid_o,
	input  wire logic                s_axi_rready_i,

	// Instruction request from fetch
	input  wire logic                req_valid_i,
	output logic                     req_ready_o,
	input  wire op_e                 req_op_i,
	input  wire logic [SEL_W-1:0]    req_flag_sel_i,
	input  wire logic [DISP_W-1:0]   req_disp_i,
	input  wire logic [PCW-1:0]      req_pc_i,
	input  wire logic                req_next_two_words_i,

	// Operand sources
	input  wire logic [FLAGS_W-1:0]  status_flag_register_i,
	input  wire logic                io_bit_i,

	// Program counter control
	output logic                     pc_load_o,
	output logic [PCW-1:0]           pc_target_o,
	output logic                     flush_o,
	output logic                     done_o,
	output logic                     taken_o
);

	state_e         state_r;
	logic [1:0]     discard_cnt_r;
	logic           pc_load_r;
	logic [PCW-1:0] pc_target_r;
	logic           flush_r;
	logic           done_r;
	logic           taken_r;
	logic           skip_r;

	logic           ctrl_en_r;
	logic           clr_cnt;
	logic [31:0]    eval_cnt_r;
	logic [31:0]    taken_cnt_r;

	logic           aw_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic           w_held_r;
	logic [31:0]    w_data_r;
	logic [3:0]     w_strb_r;
	logic           bvalid_r;
	logic [1:0]     bresp_r;
	logic           do_write;
	logic           rvalid_r;
	logic [1:0]     rresp_r;
	logic [31:0]    rdata_r;

	logic           accept;
	logic           ev_taken;
	logic           ev_skip;
	logic [PCW-1:0] ev_target;
	logic [1:0]     ev_extra;

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		reg_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_LAST_TARGET) ||
			(a == REG_EVAL_COUNT) || (a == REG_TAKEN_COUNT);
	endfunction

	cond_eval #(
		.PCW(PCW)
	) u_eval (
		.op_i             (req_op_i),
		.flag_sel_i       (req_flag_sel_i),
		.disp_i           (req_disp_i),
		.pc_i             (req_pc_i),
		.next_two_words_i (req_next_two_words_i),
		.flags_i          (status_flag_register_i),
		.io_bit_i         (io_bit_i),
		.taken_o          (ev_taken),
		.skip_o           (ev_skip),
		.target_o         (ev_target),
		.extra_o          (ev_extra)
	);

	// A new instruction is only taken once the previous one has fully retired
	assign req_ready_o = ctrl_en_r && (state_r == ST_IDLE);
	assign accept = req_valid_i && req_ready_o;

	// Sequencer: first cycle evaluates, extra cycles discard fetched words
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
			discard_cnt_r <= EXTRA_NONE;
			flush_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (accept)
					begin
						if (ev_extra == EXTRA_NONE)
						begin
							done_r <= 1'b1;
						end
						else
						begin
							state_r <= ST_DISCARD;
							discard_cnt_r <= ev_extra;
							flush_r <= 1'b1;
						end
					end
				end
				ST_DISCARD:
				begin
					if (discard_cnt_r == EXTRA_ONE)
					begin
						state_r <= ST_IDLE;
						flush_r <= 1'b0;
						done_r <= 1'b1;
					end
					discard_cnt_r <= discard_cnt_r - EXTRA_ONE;
				end
				default:
				begin
					state_r <= ST_IDLE;
					flush_r <= 1'b0;
				end
			endcase
		end
	end

	// Outcome registers, loaded once per accepted instruction
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pc_load_r <= 1'b0;
			pc_target_r <= '0;
			taken_r <= 1'b0;
			skip_r <= 1'b0;
		end
		else
		begin
			pc_load_r <= accept;
			if (accept)
			begin
				pc_target_r <= ev_target;
				taken_r <= ev_taken;
				skip_r <= ev_skip;
			end
		end
	end

	assign pc_load_o = pc_load_r;
	assign pc_target_o = pc_target_r;
	assign flush_o = flush_r;
	assign done_o = done_r;
	assign taken_o = taken_r;

	// Statistics counters; an increment in the clear cycle survives
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			eval_cnt_r <= '0;
			taken_cnt_r <= '0;
		end
		else
		begin
			if (clr_cnt)
			begin
				eval_cnt_r <= {31'h0, accept};
				taken_cnt_r <= {31'h0, accept && ev_taken};
			end
			else
			begin
				eval_cnt_r <= eval_cnt_r + {31'h0, accept};
				taken_cnt_r <= taken_cnt_r + {31'h0, accept && ev_taken};
			end
		end
	end

	// Write address and data are captured independently
	assign s_axi_awready_o = !aw_held_r && !bvalid_r;
	assign s_axi_wready_o = !w_held_r && !bvalid_r;
	assign do_write = aw_held_r && w_held_r && !bvalid_r;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_i;
			end
			else if (do_write)
			begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			else if (do_write)
			begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else
		begin
			if (do_write)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= reg_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready_i)
			begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;

	// Control register; the clear bit is a self-clearing pulse
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_en_r <= CTRL_EN_RESET;
		end
		else if (do_write && (aw_addr_r == REG_CTRL) && w_strb_r[0])
		begin
			ctrl_en_r <= w_data_r[CTRL_EN_BIT];
		end
	end

	assign clr_cnt = do_write && (aw_addr_r == REG_CTRL) && w_strb_r[0] && w_data_r[CTRL_CLR_BIT];

	// Read channel answers one cycle after the address is taken
	assign s_axi_arready_o = !rvalid_r;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end
		else
		begin
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				rvalid_r <= 1'b1;
				rresp_r <= reg_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= '0;
				case (s_axi_araddr_i)
					REG_CTRL: rdata_r[CTRL_EN_BIT] <= ctrl_en_r;
					REG_STATUS:
					begin
						rdata_r[STAT_BUSY_BIT] <= state_r != ST_IDLE;
						rdata_r[STAT_TAKEN_BIT] <= taken_r;
						rdata_r[STAT_SKIP_BIT] <= skip_r;
					end
					REG_LAST_TARGET: rdata_r[PCW-1:0] <= pc_target_r;
					REG_EVAL_COUNT: rdata_r <= eval_cnt_r;
					REG_TAKEN_COUNT: rdata_r <= taken_cnt_r;
					default: rdata_r <= '0;
				endcase
			end
			else if (s_axi_rready_i)
			begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdata_r;

endmodule
`default_nettype wire

// >>> tb/cbsu_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module cbsu_asserts
	import cbsu_pkg::*;
#(
	parameter int PCW = PC_W
)
(
	// Clock, reset and request
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              req_valid_i,
	input  wire logic              req_ready_o,
	input  wire op_e               req_op_i,
	input  wire logic [DISP_W-1:0] req_disp_i,
	input  wire logic [PCW-1:0]    req_pc_i,
	input  wire logic              req_next_two_words_i,
	// Outcome and bus
	input  wire logic              pc_load_o,
	input  wire logic [PCW-1:0]    pc_target_o,
	input  wire logic              flush_o,
	input  wire logic              done_o,
	input  wire logic              taken_o,
	input  wire logic              s_axi_arvalid_i,
	input  wire logic              s_axi_arready_o,
	input  wire logic              s_axi_rvalid_o,
	input  wire logic              s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i
);
	logic [PCW-1:0] pc_r;
	logic [PCW-1:0] jmp_r;
	logic           skp_r;
	logic           two_r;
	wire            acc = req_valid_i && req_ready_o;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Operands of the accepted instruction
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pc_r <= '0;
			jmp_r <= '0;
			skp_r <= 1'b0;
			two_r <= 1'b0;
		end
		else if (acc)
		begin
			pc_r <= req_pc_i;
			jmp_r <= req_pc_i + PCW'({{(PCW-DISP_W){req_disp_i[DISP_W-1]}}, req_disp_i}) + 1'b1;
			skp_r <= req_op_i == OP_SKIP_IF_IO_BIT_SET;
			two_r <= req_next_two_words_i;
		end
	end

	load_after_accept_a: assert property (acc |=> pc_load_o) else $error("no load");
	load_has_cause_a: assert property (pc_load_o |-> $past(acc)) else $error("stray load");
	untaken_one_a: assert property (pc_load_o && !taken_o |-> done_o && !flush_o
		&& pc_target_o == pc_r + 1'b1) else $error("untaken");
	branch_target_a: assert property (pc_load_o && taken_o && !skp_r |-> pc_target_o == jmp_r)
		else $error("branch target");
	taken_two_a: assert property (pc_load_o && taken_o && !(skp_r && two_r) |->
		flush_o && !done_o ##1 !flush_o && done_o) else $error("taken timing");
	skip_target_a: assert property (pc_load_o && taken_o && skp_r |->
		pc_target_o == pc_r + (two_r ? 2'h3 : 2'h2)) else $error("skip target");
	skip_long_a: assert property (pc_load_o && taken_o && skp_r && two_r |->
		flush_o [*2] ##1 done_o) else $error("skip timing");
	flush_blocks_a: assert property (flush_o |-> !req_ready_o) else $error("ready in flush");
	read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("no rvalid");
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("bvalid dropped");
	c_taken: cover property (pc_load_o && taken_o && !skp_r);
	c_skip2: cover property (pc_load_o && taken_o && skp_r && two_r);
	c_untaken: cover property (pc_load_o && !taken_o);
endmodule
bind conditional_branch_skip_unit cbsu_asserts #(.PCW(PCW)) chk_i (.mclk_i(mclk_i),
	.rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
	.req_disp_i(req_disp_i), .req_pc_i(req_pc_i), .req_next_two_words_i(req_next_two_words_i),
	.pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .flush_o(flush_o), .done_o(done_o),
	.taken_o(taken_o), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i));
`default_nettype wire

// >>> tb/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_model
	import cbsu_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// Bench command and observed state
	input  wire logic              go_i,
	input  wire op_e               op_i,
	input  wire logic [SEL_W-1:0]  sel_i,
	input  wire logic [DISP_W-1:0] disp_i,
	input  wire logic [PC_W-1:0]   pc_i,
	input  wire logic              two_i,
	output logic [PC_W-1:0]        pc_o,
	output logic [1:0]             cyc_o,
	// Request to the unit
	output logic                   req_valid_o,
	input  wire logic              req_ready_i,
	output var op_e                req_op_o,
	output logic [SEL_W-1:0]       req_sel_o,
	output logic [DISP_W-1:0]      req_disp_o,
	output logic [PC_W-1:0]        req_pc_o,
	output logic                   req_two_o,
	// Counter control from the unit
	input  wire logic              pc_load_i,
	input  wire logic [PC_W-1:0]   pc_target_i,
	input  wire logic              done_i
);
	logic [1:0] cnt_r;
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_valid_o <= 1'b0;
			req_op_o <= OP_BRANCH_ON_FLAG_BIT_SET;
			{req_sel_o, req_disp_o, req_pc_o, req_two_o} <= '0;
			{pc_o, cyc_o, cnt_r} <= '0;
		end
		else
		begin
			if (go_i)
			begin
				req_valid_o <= 1'b1;
				req_op_o <= op_i;
				{req_sel_o, req_disp_o, req_pc_o, req_two_o} <= {sel_i, disp_i, pc_i, two_i};
			end
			else if (req_valid_o && req_ready_i)
				req_valid_o <= 1'b0;
			// Idle payload keeps moving so stale values cannot pass
			else if (!req_valid_o)
				{req_sel_o, req_disp_o, req_pc_o, req_two_o} <= ~{req_sel_o, req_disp_o, req_pc_o, req_two_o};
			cnt_r <= (req_valid_o && req_ready_i) ? 2'h1 : cnt_r + 2'h1;
			if (done_i)
				cyc_o <= cnt_r;
			if (pc_load_i)
				pc_o <= pc_target_i;
		end
	end
endmodule
`default_nettype wire

// >>> tb/conditional_branch_skip_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_skip_unit_tb_top
	import cbsu_pkg::*;
;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr = '0, araddr = '0, flags = '0;
	logic [31:0] wdata = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic go = 1'b0, io = 1'b0, two = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rv, rdy, rtwo, load, flush, done, taken, mtwo;
	logic [1:0] bresp, rresp, cyc;
	logic [2:0] sel, rsel;
	logic [6:0] disp, rdisp;
	logic [15:0] pc, rpc, tgt, mpc;
	op_e op = OP_BRANCH_IF_EQUAL;
	op_e rop;
	int n_mismatch = 0, checks_done = 0, n_iss = 0, n_tk = 0;

	conditional_branch_skip_unit uut (.mclk_i(mclk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .req_valid_i(rv), .req_ready_o(rdy), .req_op_i(rop),
		.req_flag_sel_i(rsel), .req_disp_i(rdisp), .req_pc_i(rpc), .req_next_two_words_i(rtwo),
		.status_flag_register_i(flags), .io_bit_i(io), .pc_load_o(load), .pc_target_o(tgt),
		.flush_o(flush), .done_o(done), .taken_o(taken));
	fetch_model fm (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .op_i(op), .sel_i(sel),
		.disp_i(disp), .pc_i(pc), .two_i(two), .pc_o(mpc), .cyc_o(cyc), .req_valid_o(rv),
		.req_ready_i(rdy), .req_op_o(rop), .req_sel_o(rsel), .req_disp_o(rdisp),
		.req_pc_o(rpc), .req_two_o(rtwo), .pc_load_i(load), .pc_target_i(tgt), .done_i(done));

	initial forever #5 mclk_i = ~mclk_i;

	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_i);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		forever
		begin
			@(posedge mclk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_i);
		{araddr, arvalid, rready} <= {a, 2'b11};
		forever
		begin
			@(posedge mclk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask

	function automatic logic cond(op_e o, logic [2:0] s, logic [7:0] f, logic b);
		case (o)
			OP_BRANCH_ON_FLAG_BIT_SET: return f[s];
			OP_BRANCH_ON_FLAG_BIT_CLEARED: return !f[s];
			OP_BRANCH_IF_EQUAL: return f[FLAG_Z];
			OP_BRANCH_IF_NOT_EQUAL: return !f[FLAG_Z];
			OP_BRANCH_IF_CARRY_SET: return f[FLAG_C];
			OP_BRANCH_IF_CARRY_CLEARED, OP_BRANCH_IF_SAME_OR_HIGHER: return !f[FLAG_C];
			OP_BRANCH_IF_NEGATIVE: return f[FLAG_N];
			OP_BRANCH_IF_POSITIVE: return !f[FLAG_N];
			OP_BRANCH_IF_SIGNED_GE: return !(f[FLAG_N] ^ f[FLAG_V]);
			OP_BRANCH_IF_SIGNED_LESS: return f[FLAG_N] ^ f[FLAG_V];
			OP_BRANCH_IF_HALF_CARRY_SET: return f[FLAG_H];
			OP_BRANCH_IF_HALF_CARRY_CLEAR: return !f[FLAG_H];
			OP_BRANCH_IF_TRANSFER_SET: return f[FLAG_T];
			OP_BRANCH_IF_TRANSFER_CLEAR: return !f[FLAG_T];
			default: return b;
		endcase
	endfunction

	// One instruction through the unit, judged on target, outcome and cycles
	task automatic issue(op_e o, logic [2:0] s, logic [7:0] f, logic b, logic w, logic [6:0] k);
		logic tk;
		logic sk;
		logic [15:0] p;
		logic [15:0] e;
		int n;
		p = 16'hfff0 + 16'(n_iss);
		tk = cond(o, s, f, b);
		sk = o == OP_SKIP_IF_IO_BIT_SET;
		e = !tk ? p + 16'h1 : sk ? p + 16'h2 + 16'(w) : p + {{9{k[6]}}, k} + 16'h1;
		@(posedge mclk_i);
		{flags, io, sel, disp, pc, two, go} <= {f, b, s, k, p, w, 1'b1};
		op <= o;
		@(posedge mclk_i);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 50)
		begin
			@(posedge mclk_i);
			n++;
		end
		@(negedge mclk_i);
		chk(n < 50, "no done");
		chk(taken === tk && mpc === e, "target");
		chk(cyc === (!tk ? 2'h1 : (sk && w) ? 2'h3 : 2'h2), "cycles");
		n_iss++;
		n_tk += tk;
	endtask

	task automatic sc_flag_bits();
		logic [7:0] m;
		for (int s = 0; s < 8; s++)
			for (int v = 0; v < 2; v++)
			begin
				m = 8'h1 << s;
				issue(OP_BRANCH_ON_FLAG_BIT_SET, 3'(s), v ? m : ~m, 1'b0, 1'b0, 7'h3f);
				issue(OP_BRANCH_ON_FLAG_BIT_CLEARED, 3'(s), v ? m : 8'h0, 1'b0, 1'b0, 7'h40);
			end
	endtask

	task automatic sc_named();
		logic [7:0] fl [4] = '{8'h00, 8'hff, 8'h08, 8'h04};
		logic [6:0] k;
		for (int o = 2; o < 15; o++)
			for (int i = 0; i < 4; i++)
			begin
				k = o[0] ? 7'h40 : 7'h05;
				if (o < 9)
					issue(op_e'(o), 3'h0, fl[i], 1'b0, 1'b1, k);
				else
					issue(op_e'(o), 3'h0, fl[i], 1'b0, 1'b1, k);
			end
	endtask

	task automatic sc_skip();
		for (int i = 0; i < 4; i++)
			issue(OP_SKIP_IF_IO_BIT_SET, 3'h0, 8'hff, i[0], i[1], 7'h7f);
	endtask

	task automatic sc_regs();
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] t;
		// Last scenario ends on a taken skip over a two-word instruction
		t = 16'hfff0 + 16'(n_iss - 1) + SKIP_TWO_STEP;
		axi_rd(REG_CTRL, d, r);
		chk(d === 32'h1 && r === RESP_OKAY, "ctrl reset");
		axi_rd(REG_STATUS, d, r);
		chk(d === 32'((1 << STAT_TAKEN_BIT) | (1 << STAT_SKIP_BIT)), "status");
		axi_rd(REG_LAST_TARGET, d, r);
		chk(d === {16'h0, t}, "last target");
		axi_rd(REG_EVAL_COUNT, d, r);
		chk(d === 32'(n_iss), "eval count");
		axi_rd(REG_TAKEN_COUNT, d, r);
		chk(d === 32'(n_tk), "taken count");
		axi_rd(8'h40, d, r);
		chk(r === RESP_SLVERR, "unmapped read");
		axi_wr(8'h40, 32'h1, r);
		chk(r === RESP_SLVERR, "unmapped write");
		axi_wr(REG_CTRL, 32'h0, r);
		@(negedge mclk_i);
		chk(rdy === 1'b0, "disabled");
		axi_wr(REG_CTRL, 32'h3, r);
		@(negedge mclk_i);
		chk(rdy === 1'b1, "enabled");
		axi_rd(REG_EVAL_COUNT, d, r);
		chk(d === 32'h0, "eval cleared");
		axi_rd(REG_TAKEN_COUNT, d, r);
		chk(d === 32'h0, "taken cleared");
	endtask

	initial
	begin
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		sc_flag_bits();
		sc_named();
		sc_skip();
		sc_regs();
		give_verdict();
	end

	initial
	begin
		#100us;
		n_mismatch++;
		give_verdict();
	end
endmodule
`default_nettype wire
